// File: flic_cfg.svh
// constants for the four level interrupt controller
// assumes avalon-mm word addressing by byte offset, 32-bit data
`ifndef FLIC_CFG_SVH
`define FLIC_CFG_SVH
`define FLIC_NSRC 15
`define FLIC_OFS_EN_A 8'h00
`define FLIC_OFS_EN_B 8'h04
`define FLIC_OFS_PL_A 8'h08
`define FLIC_OFS_PH_A 8'h0C
`define FLIC_OFS_PL_B 8'h10
`define FLIC_OFS_PH_B 8'h14
`define FLIC_OFS_TIMER_CONTROL_REG 8'h18
`define FLIC_OFS_STAT 8'h1C
`define FLIC_OFS_ICLR 8'h20
`define FLIC_OFS_IENA 8'h24
`define FLIC_OFS_VEC 8'h28
`define FLIC_GIE_BIT 7
`define FLIC_IT0_BIT 0
`define FLIC_IE0_BIT 1
`define FLIC_IT1_BIT 2
`define FLIC_IE1_BIT 3
`define FLIC_NEV 2
`endif

// File: flic_pkg.sv
// types shared by the interrupt controller files
// assumes flic_cfg.svh is on the include path
package flic_pkg;
    typedef logic [1:0] flic_lvl_t;
    typedef logic [3:0] flic_idx_t;
    typedef struct packed {
        logic valid;
        flic_idx_t src;
        flic_lvl_t lvl;
    } flic_grant_t;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } flic_avreq_t;
    typedef enum logic [2:0] {
        FLIC_RUN = 3'b001,
        FLIC_IDLE = 3'b010,
        FLIC_PDOWN = 3'b100
    } flic_pwr_t;
endpackage

// File: flic_arb.sv
// arbiter: highest level wins, lowest index breaks ties
// assumes level vector registered upstream; request vector arrives unregistered from pins and inputs
`timescale 1ns/10ps
module flic_arb #(
    parameter int NSRC = 15
) (
    input wire logic [NSRC-1:0] req,
    input wire logic [2*NSRC-1:0] lvl,
    output flic_pkg::flic_grant_t grant
);
    import flic_pkg::*;
    // scan from last to first so lower index wins equal levels
    always_comb begin
        grant = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && (!grant.valid || lvl[2*i +: 2] >= grant.lvl)) begin // R8 R9
                grant.valid = 1'b1;
                grant.src = 4'(i);
                grant.lvl = lvl[2*i +: 2];
            end
        end
    end
endmodule

// File: flic_top.sv
// four level interrupt controller with avalon-mm register slave
// assumes core pulses vector_ack on vectoring and reti_pulse on return
// How it works
// R1: four priority levels for service
// R2: fifteen request sources accepted
// R3: per-source enable bit gates each request
// R4: global enable blocks every request
// R5: level per source from low/high bit pair
// R6: only strictly higher level preempts
// R7: top level routine never preempted
// R8: highest pending level granted
// R9: fixed index order breaks equal levels
// R10: trigger type bit per external input
// R11: high then low sample sets flag
// R12: enabled external interrupt wakes sleep modes
// R13: any enabled source ends idle
// R14: level follows pin; edge flag clears on vector
// R15: report vector, track active levels
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "flic_cfg.svh"
module flic_top #(
    parameter int NSRC = `FLIC_NSRC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [1:0] ext_request_pin,
    input wire logic [NSRC-3:0] periph_req,
    input wire logic enter_idle,
    input wire logic enter_pdown,
    output logic core_wake,
    output logic in_idle,
    output logic in_pdown,
    output logic irq_to_core,
    output flic_pkg::flic_idx_t irq_vector,
    input wire logic vector_ack,
    input wire logic reti_pulse,
    output logic [3:0] active_levels,
    output logic event_irq
);
    import flic_pkg::*;

    typedef struct packed {
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [7:0] pl_a;
        logic [7:0] ph_a;
        logic [7:0] pl_b;
        logic [7:0] ph_b;
        logic [1:0] trig;
        logic [1:0] ext_flag;
        logic [1:0] pin_prev;
        logic [3:0] active;
        logic irq;
        flic_idx_t vec;
        flic_pwr_t pwr;
        logic [`FLIC_NEV-1:0] ev_stat;
        logic [`FLIC_NEV-1:0] ev_ena;
        logic ack_pend;
        logic [31:0] rdata;
    } flic_state_t;

    flic_state_t s_q;
    flic_state_t s_d;
    logic [NSRC-1:0] raw_req;
    logic [NSRC-1:0] en_vec;
    logic [NSRC-1:0] gated;
    logic [2*NSRC-1:0] lvl_vec;
    logic [NSRC-1:0] hi_vec;
    logic [NSRC-1:0] lo_vec;
    logic [1:0] ext_level;
    logic [1:0] ext_req;
    flic_grant_t grant;
    logic [1:0] cur_lvl;
    logic preempt;
    logic wr_hit;
    logic rd_hit;
    logic [`FLIC_NEV-1:0] ev_set;

    // sources: ext0, ext1 first, peripherals after in fixed order
    assign en_vec = {s_q.en_b[NSRC-8:0], s_q.en_a[6:0]}; // R2 R3
    assign lo_vec = {s_q.pl_b[NSRC-8:0], s_q.pl_a[6:0]};
    assign hi_vec = {s_q.ph_b[NSRC-8:0], s_q.ph_a[6:0]};

    // pin is active low; level mode follows it directly
    assign ext_level = ~ext_request_pin;
    generate
        for (genvar g = 0; g < 2; g++) begin : g_ext
            assign ext_req[g] = s_q.trig[g] ? s_q.ext_flag[g] : ext_level[g]; // R10 R14
        end
    endgenerate
    assign raw_req = {periph_req, ext_req};

    // level of each source is the high:low bit pair
    generate
        for (genvar g = 0; g < NSRC; g++) begin : g_lvl
            assign lvl_vec[2*g +: 2] = {hi_vec[g], lo_vec[g]}; // R1 R5
        end
    endgenerate

    assign gated = raw_req & en_vec & {NSRC{s_q.en_a[`FLIC_GIE_BIT]}}; // R3 R4

    flic_arb #(
        .NSRC(NSRC)
    ) u_arb (
        .req(gated),
        .lvl(lvl_vec),
        .grant(grant)
    );

    // current level is highest active bit
    always_comb begin
        cur_lvl = 2'd0;
        for (int i = 0; i < 4; i++) begin
            if (s_q.active[i]) begin
                cur_lvl = 2'(i);
            end
        end
    end

    // strict compare keeps equal level waiting; level 3 can never be topped
    assign preempt = grant.valid && (s_q.active == 4'b0000 || grant.lvl > cur_lvl); // R6 R7

    assign wr_hit = avs_write && clk_en;
    assign rd_hit = avs_read && clk_en;

    // next-state for everything
    always_comb begin
        s_d = s_q;
        ev_set = '0;
        // edge detect on the synchronous pin sample
        s_d.pin_prev = ext_request_pin;
        for (int i = 0; i < 2; i++) begin
            if (s_q.trig[i] && ext_request_pin[i] == 1'b0 && s_q.pin_prev[i] == 1'b1) begin
                s_d.ext_flag[i] = 1'b1; // R11
            end else if (vector_ack && s_q.vec == 4'(i) && s_q.irq) begin
                s_d.ext_flag[i] = 1'b0; // R14
            end
        end
        // request held to the core until it vectors
        s_d.irq = preempt && !vector_ack;
        if (preempt && !vector_ack) begin
            s_d.vec = grant.src; // R15
        end
        // active level stack; return pops the highest
        if (reti_pulse) begin
            s_d.active[cur_lvl] = 1'b0; // R15
        end
        if (vector_ack && s_q.irq) begin
            s_d.active[lvl_vec[2*s_q.vec +: 2]] = 1'b1; // R15
            ev_set[1] = 1'b1;
            s_d.ev_stat[1] = 1'b1;
        end
        // power state; a sleep request is taken even with a request pending, power-down over idle
        unique case (s_q.pwr)
            FLIC_RUN: begin
                if (enter_pdown) begin
                    s_d.pwr = FLIC_PDOWN;
                end else if (enter_idle) begin
                    s_d.pwr = FLIC_IDLE;
                end
            end
            FLIC_IDLE: begin
                if (|gated) begin
                    s_d.pwr = FLIC_RUN; // R13 R12
                    ev_set[0] = 1'b1;
                    s_d.ev_stat[0] = 1'b1;
                end
            end
            FLIC_PDOWN: begin
                if (|gated[1:0]) begin
                    s_d.pwr = FLIC_RUN; // R12
                    ev_set[0] = 1'b1;
                    s_d.ev_stat[0] = 1'b1;
                end
            end
            default: s_d.pwr = FLIC_RUN;
        endcase
        // register writes; clear register loses to a same-cycle set
        // a write lands only on the accepting edge, when waitrequest is low
        if (wr_hit && s_q.ack_pend) begin
            unique case (avs_address)
                `FLIC_OFS_EN_A: s_d.en_a = avs_writedata[7:0];
                `FLIC_OFS_EN_B: s_d.en_b = avs_writedata[7:0];
                `FLIC_OFS_PL_A: s_d.pl_a = avs_writedata[7:0];
                `FLIC_OFS_PH_A: s_d.ph_a = avs_writedata[7:0];
                `FLIC_OFS_PL_B: s_d.pl_b = avs_writedata[7:0];
                `FLIC_OFS_PH_B: s_d.ph_b = avs_writedata[7:0];
                `FLIC_OFS_TIMER_CONTROL_REG: begin
                    s_d.trig[0] = avs_writedata[`FLIC_IT0_BIT];
                    s_d.trig[1] = avs_writedata[`FLIC_IT1_BIT];
                    // software may clear flags; a new edge still wins
                    if (!avs_writedata[`FLIC_IE0_BIT] && s_d.ext_flag[0] == s_q.ext_flag[0]) begin
                        s_d.ext_flag[0] = 1'b0;
                    end
                    if (!avs_writedata[`FLIC_IE1_BIT] && s_d.ext_flag[1] == s_q.ext_flag[1]) begin
                        s_d.ext_flag[1] = 1'b0;
                    end
                end
                `FLIC_OFS_ICLR: begin
                    s_d.ev_stat = (s_q.ev_stat & ~avs_writedata[`FLIC_NEV-1:0]) | ev_set;
                end
                `FLIC_OFS_IENA: s_d.ev_ena = avs_writedata[`FLIC_NEV-1:0];
                default: ;
            endcase
        end
        // read data registered; unmapped reads give zero
        s_d.ack_pend = (rd_hit || wr_hit) && !s_q.ack_pend;
        if (rd_hit && !s_q.ack_pend) begin
            unique case (avs_address)
                `FLIC_OFS_EN_A: s_d.rdata = {24'h00_0000, s_q.en_a};
                `FLIC_OFS_EN_B: s_d.rdata = {24'h00_0000, s_q.en_b};
                `FLIC_OFS_PL_A: s_d.rdata = {24'h00_0000, s_q.pl_a};
                `FLIC_OFS_PH_A: s_d.rdata = {24'h00_0000, s_q.ph_a};
                `FLIC_OFS_PL_B: s_d.rdata = {24'h00_0000, s_q.pl_b};
                `FLIC_OFS_PH_B: s_d.rdata = {24'h00_0000, s_q.ph_b};
                `FLIC_OFS_TIMER_CONTROL_REG: s_d.rdata = {28'h000_0000, s_q.ext_flag[1], s_q.trig[1],
                    s_q.ext_flag[0], s_q.trig[0]};
                `FLIC_OFS_STAT: s_d.rdata = {30'h0000_0000, s_q.ev_stat};
                `FLIC_OFS_IENA: s_d.rdata = {30'h0000_0000, s_q.ev_ena};
                `FLIC_OFS_VEC: s_d.rdata = {20'h0_0000, s_q.active, s_q.irq, 3'h0, s_q.vec};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register; clock enable freezes all of it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.pin_prev <= 2'b11;
            s_q.pwr <= FLIC_RUN;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // one wait cycle per access, answer on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack_pend;
    assign avs_readdata = s_q.rdata;
    assign irq_to_core = s_q.irq;
    assign irq_vector = s_q.vec;
    assign active_levels = s_q.active;
    assign in_idle = s_q.pwr == FLIC_IDLE;
    assign in_pdown = s_q.pwr == FLIC_PDOWN;
    assign core_wake = s_q.pwr == FLIC_RUN;
    assign event_irq = |(s_q.ev_stat & s_q.ev_ena);
endmodule

// File: flic_top_assertions.sv
// checker on the ports of flic_top
// assumes clk_en held high by the bench
`timescale 1ns/10ps
module flic_top_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic core_wake,
    input wire logic in_idle,
    input wire logic in_pdown,
    input wire logic irq_to_core,
    input wire logic vector_ack,
    input wire logic reti_pulse,
    input wire logic [3:0] active_levels
);
    import flic_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // grant withdrawn once the core vectors
    a_irq_drops: assert property (irq_to_core && vector_ack |=> !irq_to_core)
        else $error("grant held after vector ack");
    // new level must sit above every level already in service
    a_level_higher: assert property (irq_to_core && vector_ack |=>
        (active_levels & ~$past(active_levels)) > $past(active_levels))
        else $error("vector taken without higher level");
    a_wait_first: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
        else $error("no wait cycle on access");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait");
    // top level routine blocks every new grant
    a_top_hold: assert property (active_levels[3] && !irq_to_core && !reti_pulse |=> !irq_to_core)
        else $error("grant during top level routine");
    a_wake_run: assert property (core_wake |-> !in_idle && !in_pdown)
        else $error("awake while sleeping");
    a_reti_pops: assert property (reti_pulse && !vector_ack && $onehot(active_levels) |=>
        active_levels == 4'h0)
        else $error("return left a level active");
    a_rdata_holds: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
endmodule

// File: flic_core_model.sv
// core model: acknowledges grants, returns after a fixed run
// assumes irq_to_core is a level held until acknowledged
`timescale 1ns/10ps
module flic_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic irq_to_core,
    input wire logic slow,
    output logic vector_ack,
    output logic reti_pulse
);
    logic [3:0] wait_q;
    logic [4:0] run_q;
    logic [3:0] depth_q;
    logic ack_go;
    logic ret_go;
    // one ack per grant; a slow core lets the grant stand a while
    assign ack_go = irq_to_core && !vector_ack && wait_q >= (slow ? 4'h6 : 4'h0);
    // return only while a routine is in service; nesting keeps a depth
    assign ret_go = run_q == 5'h1 && !ack_go;
    always_ff @(posedge clk_sys) begin
        vector_ack <= ack_go;
        reti_pulse <= ret_go;
        if (rst) begin
            wait_q <= 4'h0;
            run_q <= 5'h0;
            depth_q <= 4'h0;
            vector_ack <= 1'b0;
            reti_pulse <= 1'b0;
        end else begin
            wait_q <= (irq_to_core && !ack_go) ? wait_q + 4'h1 : 4'h0;
            depth_q <= depth_q + {3'h0, ack_go} - {3'h0, ret_go};
            if (ack_go || (ret_go && depth_q > 4'h1)) begin
                run_q <= 5'h14;
            end else if (run_q != 5'h0) begin
                run_q <= run_q - 5'h1;
            end
        end
    end
endmodule

// File: four_level_interrupt_controller_tb.sv
// self-checking bench for flic_top with a core model
// assumes clk_en and power-down request tied off
`timescale 1ns/10ps
module four_level_interrupt_controller_tb;
    import flic_pkg::*;
    logic clk_sys, rst, avs_read, avs_write, enter_idle, slow, vector_ack, reti_pulse;
    logic avs_waitrequest, core_wake, in_idle, in_pdown, irq_to_core, event_irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0] ext_request_pin;
    logic [12:0] periph_req;
    logic [3:0] active_levels;
    flic_idx_t irq_vector;
    logic [31:0] exp_rd[$];
    flic_idx_t exp_vec[$];
    int fails = 0, num_checks = 0, cyc = 0, s;
    flic_top dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_request_pin(ext_request_pin), .periph_req(periph_req), .enter_idle(enter_idle),
        .enter_pdown(1'b0), .core_wake(core_wake), .in_idle(in_idle), .in_pdown(in_pdown),
        .irq_to_core(irq_to_core), .irq_vector(irq_vector), .vector_ack(vector_ack),
        .reti_pulse(reti_pulse), .active_levels(active_levels), .event_irq(event_irq));
    flic_core_model core (.clk_sys(clk_sys), .rst(rst), .irq_to_core(irq_to_core),
        .slow(slow), .vector_ack(vector_ack), .reti_pulse(reti_pulse));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // request held until waitrequest seen low before an edge
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk_sys);
        if (!w) exp_rd.push_back(e);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // note the expected source, then withdraw its request once vectored
    task serve(input flic_idx_t v);
        int n;
        exp_vec.push_back(v);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (!(irq_to_core === 1'b1 && vector_ack === 1'b1) && n < 300);
        @(posedge clk_sys);
        if (v >= 2) periph_req[v-2] <= 1'b0;
        ext_request_pin <= 2'h3;
    endtask
    // oldest note compared when a vector or read data appears
    always @(negedge clk_sys) begin
        if (irq_to_core === 1'b1 && vector_ack === 1'b1) check(irq_vector, exp_vec.pop_front());
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(avs_readdata, exp_rd.pop_front());
    end
    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 30000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {rst, avs_read, avs_write, enter_idle, slow} = 5'h10;
        {avs_address, avs_writedata, periph_req} = '0;
        ext_request_pin = 2'h3;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        s = $urandom(34);
        bus(8'h3C, 0, 0, 32'h0000_0000);
        bus(8'h00, 1, 32'h0000_00FF, 0);
        bus(8'h04, 1, 32'h0000_00FF, 0);
        bus(8'h00, 0, 0, 32'h0000_00FF);
        bus(8'h20, 0, 0, 32'h0000_0000);
        bus(8'h24, 1, 32'h0000_0003, 0);
        bus(8'h18, 1, 32'h0000_0001, 0);
        ext_request_pin <= 2'h2;
        serve(0);
        bus(8'h1C, 0, 0, 32'h0000_0002);
        check(event_irq, 1);
        bus(8'h20, 1, 32'h0000_0003, 0);
        @(negedge clk_sys);
        check(event_irq, 0);
        $display("edge and event test done");
        periph_req <= 13'h0003;
        serve(2);
        serve(3);
        bus(8'h0C, 1, 32'h0000_0008, 0);
        periph_req <= 13'h0003;
        serve(3);
        serve(2);
        bus(8'h08, 1, 32'h0000_0008, 0);
        periph_req <= 13'h0003;
        serve(3);
        serve(2);
        bus(8'h08, 1, 32'h0000_0000, 0);
        bus(8'h0C, 1, 32'h0000_0000, 0);
        $display("priority test done");
        bus(8'h00, 1, 32'h0000_007F, 0);
        periph_req <= 13'h0002;
        repeat (30) @(negedge clk_sys);
        check(irq_to_core, 0);
        bus(8'h00, 1, 32'h0000_00FF, 0);
        serve(3);
        for (int i = 0; i < 8; i++) begin
            s = $urandom_range(14, 2);
            @(posedge clk_sys);
            slow <= $urandom_range(1, 0);
            periph_req[s-2] <= 1'b1;
            serve(s[3:0]);
        end
        $display("random source test done");
        while (active_levels !== 4'h0) @(posedge clk_sys);
        enter_idle <= 1'b1;
        @(posedge clk_sys);
        enter_idle <= 1'b0;
        repeat (3) @(negedge clk_sys);
        check(in_idle, 1);
        @(posedge clk_sys);
        periph_req[5] <= 1'b1;
        serve(7);
        check(core_wake, 1);
        check(exp_vec.size(), 0);
        $display("idle test done");
        tally_and_finish();
    end
endmodule
bind flic_top flic_top_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .core_wake(core_wake), .in_idle(in_idle), .in_pdown(in_pdown), .irq_to_core(irq_to_core),
    .vector_ack(vector_ack), .reti_pulse(reti_pulse), .active_levels(active_levels));
